// >>> logic/dual_space_agu.sv
`timescale 1ns/100ps
module dual_space_agu #(
  parameter int NUM_REGS = 16
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Decoded instruction.
  input wire logic i_valid,
  input wire agu_pkg::class_e i_class,
  input wire agu_pkg::mode_e i_src_mode,
  input wire agu_pkg::mode_e i_dst_mode,
  input wire logic [agu_pkg::REG_IDX_W-1:0] i_src_reg,
  input wire logic [agu_pkg::REG_IDX_W-1:0] i_dst_reg,
  input wire logic [agu_pkg::OFFS_FIELD_W-1:0] i_offset_register_field,
  input wire logic [agu_pkg::ADDR_W-1:0] i_literal,
  input wire logic i_dst_write,
  // Multiply-accumulate prefetch fields.
  input wire logic [agu_pkg::REG_IDX_W-1:0] i_x_ptr,
  input wire agu_pkg::mac_mode_e i_x_mac_mode,
  input wire agu_pkg::post_step_e i_x_step,
  input wire logic [agu_pkg::REG_IDX_W-1:0] i_y_ptr,
  input wire agu_pkg::mac_mode_e i_y_mac_mode,
  input wire agu_pkg::post_step_e i_y_step,
  // Modulo and bit-reverse settings.
  input wire logic i_x_mod_en,
  input wire logic [agu_pkg::ADDR_W-1:0] i_x_mod_start,
  input wire logic [agu_pkg::ADDR_W-1:0] i_x_mod_end,
  input wire logic i_y_mod_en,
  input wire logic [agu_pkg::ADDR_W-1:0] i_y_mod_start,
  input wire logic [agu_pkg::ADDR_W-1:0] i_y_mod_end,
  input wire logic i_brev_en,
  input wire logic [agu_pkg::ADDR_W-1:0] i_brev_size,
  // Write data and read data from the data RAM.
  input wire logic [agu_pkg::DATA_W-1:0] i_wr_data,
  input wire logic [agu_pkg::DATA_W-1:0] i_x_rd_data,
  input wire logic [agu_pkg::DATA_W-1:0] i_y_rd_data,
  // X read bus.
  output logic o_x_rd_en,
  output logic [agu_pkg::ADDR_W-1:0] o_x_rd_addr,
  // Y read bus.
  output logic o_y_rd_en,
  output logic [agu_pkg::ADDR_W-1:0] o_y_rd_addr,
  // X write bus, unified space.
  output logic o_x_wr_en,
  output logic [agu_pkg::ADDR_W-1:0] o_x_wr_addr,
  output logic [agu_pkg::DATA_W-1:0] o_x_wr_data,
  // Operands returned to the core.
  output logic [agu_pkg::DATA_W-1:0] o_x_operand,
  output logic [agu_pkg::DATA_W-1:0] o_y_operand,
  output logic [agu_pkg::ADDR_W-1:0] o_branch_disp,
  output logic [agu_pkg::HOLD_OFF_LIT_W-1:0] o_hold_off_count,
  // Status.
  output logic o_bad_pointer,
  output logic o_no_operand
);
  import agu_pkg::*;

  logic [ADDR_W-1:0] wreg [NUM_REGS];
  logic [ADDR_W-1:0] next_wreg [NUM_REGS];
  logic rd_pending;

  wire is_move = i_valid && i_class == CLS_MOVE;
  wire is_mac = i_valid && i_class == CLS_MAC;
  wire [ADDR_W-1:0] src_ptr = wreg[i_src_reg];
  wire [ADDR_W-1:0] dst_ptr = wreg[i_dst_reg];
  // One offset field serves both operands of a move.
  wire [ADDR_W-1:0] shared_offs = wreg[i_offset_register_field];

  // Move effective address per mode.
  function automatic logic [ADDR_W-1:0] move_ea(
    input mode_e m,
    input logic [ADDR_W-1:0] ptr,
    input logic [ADDR_W-1:0] offs,
    input logic [ADDR_W-1:0] lit
  );
    case (m)
      MODE_PRE_MOD: move_ea = ptr + WORD_STEP;
      MODE_INDEXED: move_ea = ptr + offs;
      MODE_LIT_OFFSET: move_ea = ptr + lit;
      MODE_INDIRECT, MODE_POST_MOD: move_ea = ptr;
      default: move_ea = ptr;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] step_of(input post_step_e s);
    case (s)
      POST_2: step_of = POST_STEP_2;
      POST_4: step_of = POST_STEP_4;
      POST_6: step_of = POST_STEP_6;
      default: step_of = POST_STEP_2;
    endcase
  endfunction

  // Move modes: direct and literals use no memory read.
  wire src_mem = !(i_src_mode inside {MODE_DIRECT, MODE_LIT8,
                                      MODE_LIT16});
  wire dst_mem = !(i_dst_mode inside {MODE_DIRECT, MODE_LIT8,
                                      MODE_LIT16});
  wire [ADDR_W-1:0] src_ea = move_ea(i_src_mode, src_ptr, shared_offs,
                                     i_literal);
  wire [ADDR_W-1:0] dst_ea_raw = move_ea(i_dst_mode, dst_ptr, shared_offs,
                                         i_literal);

  // Prefetch pointer legality.
  wire x_ptr_ok = i_x_ptr == X_PTR_A_IDX || i_x_ptr == X_PTR_B_IDX;
  wire y_ptr_ok = i_y_ptr == Y_PTR_A_IDX || i_y_ptr == Y_PTR_B_IDX;
  wire x_idx_ok = i_x_mac_mode != MAC_INDEXED
    || i_x_ptr == X_PTR_B_IDX;
  wire y_idx_ok = i_y_mac_mode != MAC_INDEXED
    || i_y_ptr == Y_PTR_B_IDX;
  wire x_use = is_mac && i_x_mac_mode != MAC_NONE;
  wire y_use = is_mac && i_y_mac_mode != MAC_NONE;
  wire x_fetch = x_use && x_ptr_ok && x_idx_ok;
  wire y_fetch = y_use && y_ptr_ok && y_idx_ok;
  wire bad = (x_use && !(x_ptr_ok && x_idx_ok))
    || (y_use && !(y_ptr_ok && y_idx_ok));

  wire [ADDR_W-1:0] x_ptr_val = wreg[i_x_ptr];
  wire [ADDR_W-1:0] y_ptr_val = wreg[i_y_ptr];
  wire [ADDR_W-1:0] x_mac_ea = i_x_mac_mode == MAC_INDEXED
    ? x_ptr_val + wreg[i_offset_register_field] : x_ptr_val;
  wire [ADDR_W-1:0] y_mac_ea = i_y_mac_mode == MAC_INDEXED
    ? y_ptr_val + wreg[i_offset_register_field] : y_ptr_val;

  // Post-modified pointers pass through the modulo wrapper.
  wire [ADDR_W-1:0] x_post;
  wire [ADDR_W-1:0] y_post;
  wire [ADDR_W-1:0] move_post;
  wire [ADDR_W-1:0] dst_ea;
  modulo_addr #(.W(ADDR_W)) u_x_mod (
    .i_addr(x_ptr_val),
    .i_step(step_of(i_x_step)),
    .i_subtract(i_x_step == POST_NEG_2),
    .i_mod_en(i_x_mod_en),
    .i_mod_start(i_x_mod_start),
    .i_mod_end(i_x_mod_end),
    .i_brev_en(1'b0),
    .i_brev_size(i_brev_size),
    .o_addr(x_post)
  );
  modulo_addr #(.W(ADDR_W)) u_y_mod (
    .i_addr(y_ptr_val),
    .i_step(step_of(i_y_step)),
    .i_subtract(i_y_step == POST_NEG_2),
    .i_mod_en(i_y_mod_en),
    .i_mod_start(i_y_mod_start),
    .i_mod_end(i_y_mod_end),
    .i_brev_en(1'b0),
    .i_brev_size(i_brev_size),
    .o_addr(y_post)
  );
  // Move source pointer update: modulo in X space.
  modulo_addr #(.W(ADDR_W)) u_move_mod (
    .i_addr(src_ptr),
    .i_step(WORD_STEP),
    .i_subtract(1'b0),
    .i_mod_en(i_x_mod_en),
    .i_mod_start(i_x_mod_start),
    .i_mod_end(i_x_mod_end),
    .i_brev_en(1'b0),
    .i_brev_size(i_brev_size),
    .o_addr(move_post)
  );
  // Bit-reversal acts only on the destination write address.
  modulo_addr #(.W(ADDR_W)) u_brev (
    .i_addr(dst_ea_raw),
    .i_step(16'h0000),
    .i_subtract(1'b0),
    .i_mod_en(1'b0),
    .i_mod_start(i_x_mod_start),
    .i_mod_end(i_x_mod_end),
    .i_brev_en(i_brev_en && i_dst_mode == MODE_POST_MOD
      && dst_ptr < Y_SPACE_BASE),
    .i_brev_size(i_brev_size),
    .o_addr(dst_ea)
  );

  wire do_write = is_move && i_dst_write && dst_mem;
  wire mac_x_post = x_fetch && i_x_mac_mode == MAC_POST_BY;
  wire mac_y_post = y_fetch && i_y_mac_mode == MAC_POST_BY;
  wire move_src_post = is_move && src_mem && i_src_mode == MODE_POST_MOD;

  always_comb begin
    for (int r = 0; r < NUM_REGS; r++) begin
      next_wreg[r] = wreg[r];
    end
    if (move_src_post) begin
      next_wreg[i_src_reg] = move_post;
    end
    if (mac_x_post) begin
      next_wreg[i_x_ptr] = x_post;
    end
    if (mac_y_post) begin
      next_wreg[i_y_ptr] = y_post;
    end
  end

  always_ff @(posedge i_core_clk) begin
    for (int r = 0; r < NUM_REGS; r++) begin
      wreg[r] <= i_rst_b ? next_wreg[r] : 16'h0000;
    end
  end

  // Unified reads go over the X read bus; MAC adds the Y bus.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_x_rd_en <= 1'b0;
      o_x_rd_addr <= 16'h0000;
      o_y_rd_en <= 1'b0;
      o_y_rd_addr <= 16'h0000;
    end else begin
      o_x_rd_en <= (is_move && src_mem) || x_fetch;
      o_x_rd_addr <= x_fetch ? x_mac_ea : src_ea;
      o_y_rd_en <= y_fetch;
      o_y_rd_addr <= y_mac_ea;
    end
  end

  // Writes use the unified address on the separate write bus.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_x_wr_en <= 1'b0;
      o_x_wr_addr <= 16'h0000;
      o_x_wr_data <= 16'h0000;
    end else begin
      o_x_wr_en <= do_write;
      o_x_wr_addr <= dst_ea;
      o_x_wr_data <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      rd_pending <= 1'b0;
      o_x_operand <= 16'h0000;
      o_y_operand <= 16'h0000;
    end else begin
      rd_pending <= o_x_rd_en || o_y_rd_en;
      if (o_x_rd_en) begin
        o_x_operand <= i_x_rd_data;
      end
      if (o_y_rd_en) begin
        o_y_operand <= i_y_rd_data;
      end
    end
  end

  // Literal fields and implied or absent operands.
  wire [ADDR_W-1:0] disp_ext = i_literal;
  wire [HOLD_OFF_LIT_W-1:0] hold_lit = i_literal[HOLD_OFF_LIT_W-1:0];
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_branch_disp <= 16'h0000;
      o_hold_off_count <= 14'h0000;
      o_bad_pointer <= 1'b0;
      o_no_operand <= 1'b0;
    end else begin
      if (i_valid && i_class == CLS_BRANCH) begin
        o_branch_disp <= disp_ext;
      end
      if (i_valid && i_class == CLS_HOLD_OFF) begin
        o_hold_off_count <= hold_lit;
      end
      o_bad_pointer <= bad;
      o_no_operand <= i_valid && (i_class == CLS_NO_OPERAND
        || i_class == CLS_IMPLIED);
    end
  end
endmodule

// >>> logic/agu_pkg.sv
// Functional notes
// - X space takes every instruction and mode.
// - X space has separate read/write buses.
// - X read bus serves unified and X prefetch.
// - Y space reads concurrently for MAC class.
// - Modulo wrapping on both X and Y.
// - Bit-reversal only on X-space writes.
// - All writes use unified X+Y range.
// - X/Y boundary fixed, not programmable.
// - Move/accumulator ops add indexed mode.
// - Move shares one 4-bit offset field.
// - Move modes: direct through 16-bit literal.
// - Prefetch pointers limited to registers 8..11.
// - Pointers 8,9 to X; 10,11 to Y.
// - MAC indexed only on pointers 9, 11.
// - MAC modes: indirect, indexed, post 2/4/6 or -2.
// - Branch 16-bit signed, hold-off 14-bit unsigned.
// - Implied or absent operands per opcode.
package agu_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_IDX_W = 4;
  localparam int OFFS_FIELD_W = 4;
  localparam int BRANCH_LIT_W = 16;
  localparam int HOLD_OFF_LIT_W = 14;
  localparam int BYTE_LIT_W = 8;
  localparam logic [ADDR_W-1:0] Y_SPACE_BASE = 16'h0800;
  localparam logic [REG_IDX_W-1:0] X_PTR_A_IDX = 4'h8;
  localparam logic [REG_IDX_W-1:0] X_PTR_B_IDX = 4'h9;
  localparam logic [REG_IDX_W-1:0] Y_PTR_A_IDX = 4'hA;
  localparam logic [REG_IDX_W-1:0] Y_PTR_B_IDX = 4'hB;
  localparam logic [ADDR_W-1:0] POST_STEP_2 = 16'h0002;
  localparam logic [ADDR_W-1:0] POST_STEP_4 = 16'h0004;
  localparam logic [ADDR_W-1:0] POST_STEP_6 = 16'h0006;
  localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
  typedef enum logic [2:0] {
    MODE_DIRECT = 3'b000,
    MODE_INDIRECT = 3'b001,
    MODE_POST_MOD = 3'b010,
    MODE_PRE_MOD = 3'b011,
    MODE_INDEXED = 3'b100,
    MODE_LIT_OFFSET = 3'b101,
    MODE_LIT8 = 3'b110,
    MODE_LIT16 = 3'b111
  } mode_e;
  typedef enum logic [1:0] {
    MAC_INDIRECT = 2'b00,
    MAC_POST_BY = 2'b01,
    MAC_INDEXED = 2'b10,
    MAC_NONE = 2'b11
  } mac_mode_e;
  typedef enum logic [1:0] {
    POST_2 = 2'b00,
    POST_4 = 2'b01,
    POST_6 = 2'b10,
    POST_NEG_2 = 2'b11
  } post_step_e;
  typedef enum logic [2:0] {
    CLS_MOVE = 3'b000,
    CLS_MAC = 3'b001,
    CLS_BRANCH = 3'b010,
    CLS_HOLD_OFF = 3'b011,
    CLS_IMPLIED = 3'b100,
    CLS_NO_OPERAND = 3'b101,
    CLS_OTHER = 3'b110
  } class_e;
endpackage

// >>> logic/modulo_addr.sv
`timescale 1ns/100ps
// Modulo-wraps an address into [start, end] and optionally bit-reverses.
module modulo_addr #(
  parameter int W = 16
) (
  // Address in.
  input wire logic [W-1:0] i_addr,
  input wire logic [W-1:0] i_step,
  input wire logic i_subtract,
  // Modulo window.
  input wire logic i_mod_en,
  input wire logic [W-1:0] i_mod_start,
  input wire logic [W-1:0] i_mod_end,
  // Bit-reverse control.
  input wire logic i_brev_en,
  input wire logic [W-1:0] i_brev_size,
  // Result.
  output logic [W-1:0] o_addr
);
  logic [W-1:0] raw;
  logic [W-1:0] len;
  logic [W-1:0] wrapped;
  logic [W-1:0] rev_sum;
  logic [W-1:0] carry_rev;
  localparam logic [W-1:0] WORD = 2;
  assign raw = i_subtract ? i_addr - i_step : i_addr + i_step;
  assign len = i_mod_end - i_mod_start + WORD;
  assign wrapped = !i_mod_en ? raw :
    (!i_subtract && raw > i_mod_end) ? raw - len :
    (i_subtract && raw < i_mod_start) ? raw + len : raw;
  // Reverse-carry add of the buffer half-size: propagates from the MSB down.
  always_comb begin
    carry_rev = '0;
    rev_sum = i_addr;
    for (int b = W - 1; b >= 0; b--) begin
      rev_sum[b] = i_addr[b] ^ i_brev_size[b] ^ carry_rev[b];
      if (b > 0) begin
        carry_rev[b-1] = (i_addr[b] & i_brev_size[b])
          | (carry_rev[b] & (i_addr[b] ^ i_brev_size[b]));
      end
    end
  end
  assign o_addr = i_brev_en ? rev_sum : wrapped;
endmodule

// >>> bench/agu_chk.sv
`timescale 1ns/100ps
module agu_chk
  import agu_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  input wire agu_pkg::class_e i_class,
  input wire logic [agu_pkg::REG_IDX_W-1:0] i_x_ptr,
  input wire agu_pkg::mac_mode_e i_x_mac_mode,
  input wire logic [agu_pkg::REG_IDX_W-1:0] i_y_ptr,
  input wire agu_pkg::mac_mode_e i_y_mac_mode,
  input wire logic [agu_pkg::ADDR_W-1:0] i_literal,
  input wire logic [agu_pkg::DATA_W-1:0] i_x_rd_data,
  input wire logic [agu_pkg::DATA_W-1:0] i_y_rd_data,
  input wire logic o_x_rd_en,
  input wire logic o_y_rd_en,
  input wire logic o_x_wr_en,
  input wire logic [agu_pkg::DATA_W-1:0] o_x_operand,
  input wire logic [agu_pkg::DATA_W-1:0] o_y_operand,
  input wire logic [agu_pkg::ADDR_W-1:0] o_branch_disp,
  input wire logic [agu_pkg::HOLD_OFF_LIT_W-1:0] o_hold_off_count,
  input wire logic o_bad_pointer,
  input wire logic o_no_operand
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire mac = i_valid && i_class == CLS_MAC;
  wire x_on = i_x_mac_mode != MAC_NONE;
  wire y_on = i_y_mac_mode != MAC_NONE;
  wire x_ok = i_x_ptr == X_PTR_B_IDX ||
    (i_x_ptr == X_PTR_A_IDX && i_x_mac_mode != MAC_INDEXED);
  wire y_ok = i_y_ptr == Y_PTR_B_IDX ||
    (i_y_ptr == Y_PTR_A_IDX && i_y_mac_mode != MAC_INDEXED);
  a_bad_x_ptr: assert property (mac && x_on && !x_ok |=>
    o_bad_pointer && !o_x_rd_en) else $error("bad x pointer fetched");
  a_bad_y_ptr: assert property (mac && y_on && !y_ok |=>
    o_bad_pointer && !o_y_rd_en) else $error("bad y pointer fetched");
  a_dual_fetch: assert property (mac && x_on && y_on && x_ok && y_ok |=>
    o_x_rd_en && o_y_rd_en && !o_bad_pointer) else $error("no dual fetch");
  a_x_operand: assert property (o_x_rd_en |=>
    o_x_operand == $past(i_x_rd_data)) else $error("x operand wrong");
  a_y_operand: assert property (o_y_rd_en |=>
    o_y_operand == $past(i_y_rd_data)) else $error("y operand wrong");
  a_branch_lit: assert property (i_valid && i_class == CLS_BRANCH |=>
    o_branch_disp == $past(i_literal)) else $error("branch literal wrong");
  a_hold_lit: assert property (i_valid && i_class == CLS_HOLD_OFF |=>
    o_hold_off_count == $past(i_literal[13:0])) else $error("hold-off wrong");
  a_no_operand: assert property (i_valid && (i_class == CLS_IMPLIED ||
    i_class == CLS_NO_OPERAND) |=> o_no_operand) else $error("no flag");
  a_write_cause: assert property (!i_valid |=> !o_x_wr_en)
    else $error("write without instruction");
endmodule
bind dual_space_agu agu_chk u_agu_chk (.i_core_clk, .i_rst_b, .i_valid,
  .i_class, .i_x_ptr, .i_x_mac_mode, .i_y_ptr, .i_y_mac_mode, .i_literal,
  .i_x_rd_data, .i_y_rd_data, .o_x_rd_en, .o_y_rd_en, .o_x_wr_en,
  .o_x_operand, .o_y_operand, .o_branch_disp, .o_hold_off_count,
  .o_bad_pointer, .o_no_operand);

// >>> bench/ram_model.sv
`timescale 1ns/100ps
module ram_model (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Read requests from the two generators.
  input wire logic i_x_en,
  input wire logic [15:0] i_x_addr,
  input wire logic i_y_en,
  input wire logic [15:0] i_y_addr,
  // Read data.
  output logic [15:0] o_x_data,
  output logic [15:0] o_y_data
);
  logic [15:0] x_last, y_last;
  // Idle buses show the inverse of the previous cycle's value, so the last read word returns every second idle cycle.
  always_ff @(posedge i_core_clk) begin
    x_last <= i_rst_b ? o_x_data : 16'h0000;
    y_last <= i_rst_b ? o_y_data : 16'h0000;
  end
  assign o_x_data = i_x_en ? (i_x_addr ^ 16'hA5A5) : ~x_last;
  assign o_y_data = i_y_en ? (i_y_addr ^ 16'h5A5A) : ~y_last;
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import agu_pkg::*;
  logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_valid = 1'b0;
  logic i_dst_write = 1'b0, i_x_mod_en = 1'b0, i_y_mod_en = 1'b0;
  logic i_brev_en = 1'b0;
  class_e i_class = CLS_OTHER;
  mode_e i_src_mode = MODE_DIRECT, i_dst_mode = MODE_DIRECT;
  mac_mode_e i_x_mac_mode = MAC_NONE, i_y_mac_mode = MAC_NONE;
  post_step_e i_x_step = POST_2, i_y_step = POST_2;
  logic [3:0] i_src_reg = 4'h0, i_dst_reg = 4'h0, i_x_ptr = 4'h0;
  logic [3:0] i_y_ptr = 4'h0, i_offset_register_field = 4'h0;
  logic [15:0] i_literal = 16'h0000, i_x_mod_start = 16'h0000;
  logic [15:0] i_x_mod_end = 16'h0000, i_y_mod_start = 16'h0000;
  logic [15:0] i_y_mod_end = 16'h0000, i_brev_size = 16'h0000;
  logic [15:0] i_wr_data = 16'h0000;
  wire [15:0] i_x_rd_data, i_y_rd_data, o_x_rd_addr, o_y_rd_addr;
  wire [15:0] o_x_wr_addr, o_x_wr_data, o_x_operand, o_y_operand;
  wire [15:0] o_branch_disp;
  wire [13:0] o_hold_off_count;
  wire o_x_rd_en, o_y_rd_en, o_x_wr_en, o_bad_pointer, o_no_operand;
  int miscompares = 0, compares = 0;
  dual_space_agu u_dual_space_agu (.i_core_clk, .i_rst_b, .i_valid, .i_class,
    .i_src_mode, .i_dst_mode, .i_src_reg, .i_dst_reg, .i_offset_register_field,
    .i_literal, .i_dst_write, .i_x_ptr, .i_x_mac_mode, .i_x_step, .i_y_ptr,
    .i_y_mac_mode, .i_y_step, .i_x_mod_en, .i_x_mod_start, .i_x_mod_end,
    .i_y_mod_en, .i_y_mod_start, .i_y_mod_end, .i_brev_en, .i_brev_size,
    .i_wr_data, .i_x_rd_data, .i_y_rd_data, .o_x_rd_en, .o_x_rd_addr,
    .o_y_rd_en, .o_y_rd_addr, .o_x_wr_en, .o_x_wr_addr, .o_x_wr_data,
    .o_x_operand, .o_y_operand, .o_branch_disp, .o_hold_off_count,
    .o_bad_pointer, .o_no_operand);
  ram_model u_ram_model (.i_core_clk, .i_rst_b, .i_x_en(o_x_rd_en),
    .i_x_addr(o_x_rd_addr), .i_y_en(o_y_rd_en), .i_y_addr(o_y_rd_addr),
    .o_x_data(i_x_rd_data), .o_y_data(i_y_rd_data));
  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic cmp(input string what, input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Called right after an edge; fields were set at that same edge.
  task automatic fire(input class_e c);
    i_class <= c;
    i_valid <= 1'b1;
    @(posedge i_core_clk);
    i_valid <= 1'b0;
    #1;
  endtask
  task automatic mac(input logic [3:0] xp, yp, input mac_mode_e m,
    input post_step_e xs, ys);
    @(posedge i_core_clk);
    i_x_ptr <= xp;
    i_y_ptr <= yp;
    i_x_mac_mode <= m;
    i_y_mac_mode <= m;
    i_x_step <= xs;
    i_y_step <= ys;
    fire(CLS_MAC);
  endtask
  task automatic mac_chk(input logic [3:0] xp, yp, input mac_mode_e m,
    input post_step_e xs, ys, input logic [15:0] xa, ya);
    mac(xp, yp, m, xs, ys);
    cmp("x strobe", o_x_rd_en, 1'b1);
    cmp("y strobe", o_y_rd_en, 1'b1);
    cmp("x addr", o_x_rd_addr, xa);
    cmp("y addr", o_y_rd_addr, ya);
    cmp("bad flag", o_bad_pointer, 1'b0);
    @(posedge i_core_clk);
    #1;
    cmp("x operand", o_x_operand, xa ^ 16'hA5A5);
    cmp("y operand", o_y_operand, ya ^ 16'h5A5A);
  endtask
  task automatic t_mac;
    mac_chk(4'h8, 4'hA, MAC_POST_BY, POST_2, POST_4, 16'h0000, 16'h0000);
    mac_chk(4'h8, 4'hA, MAC_POST_BY, POST_6, POST_6, 16'h0002, 16'h0004);
    mac_chk(4'h8, 4'hA, MAC_INDIRECT, POST_2, POST_2, 16'h0008, 16'h000A);
    mac_chk(4'h9, 4'hB, MAC_INDEXED, POST_2, POST_2, 16'h0000, 16'h0000);
    $display("test mac done");
  endtask
  task automatic t_modulo;
    @(posedge i_core_clk);
    i_x_mod_en <= 1'b1;
    i_x_mod_start <= 16'h0008;
    i_x_mod_end <= 16'h000A;
    mac_chk(4'h8, 4'hA, MAC_POST_BY, POST_2, POST_2, 16'h0008, 16'h000A);
    mac_chk(4'h8, 4'hA, MAC_POST_BY, POST_2, POST_2, 16'h000A, 16'h000C);
    mac_chk(4'h8, 4'hA, MAC_INDIRECT, POST_2, POST_2, 16'h0008, 16'h000E);
    $display("test modulo done");
  endtask
  // Only the illegal side is refused; the legal side still fetches.
  task automatic bad(input logic [3:0] xp, yp, input mac_mode_e m,
    input logic xe, ye);
    mac(xp, yp, m, POST_2, POST_2);
    cmp("bad flag", o_bad_pointer, 1'b1);
    cmp("x strobe", o_x_rd_en, xe);
    cmp("y strobe", o_y_rd_en, ye);
  endtask
  task automatic t_bad;
    bad(4'hA, 4'hA, MAC_POST_BY, 1'b0, 1'b1);
    bad(4'h8, 4'hB, MAC_INDEXED, 1'b0, 1'b1);
    bad(4'h9, 4'h8, MAC_POST_BY, 1'b1, 1'b0);
    bad(4'h9, 4'hA, MAC_INDEXED, 1'b1, 1'b0);
    $display("test bad pointer done");
  endtask
  task automatic lit(input class_e c, input logic [15:0] v);
    @(posedge i_core_clk);
    i_literal <= v;
    fire(c);
  endtask
  task automatic t_literal;
    lit(CLS_BRANCH, 16'h8001);
    cmp("branch", o_branch_disp, 16'h8001);
    lit(CLS_HOLD_OFF, 16'hFFFF);
    cmp("hold-off", {2'b00, o_hold_off_count}, 16'h3FFF);
    lit(CLS_IMPLIED, 16'h0000);
    cmp("implied", o_no_operand, 1'b1);
    lit(CLS_NO_OPERAND, 16'h0000);
    cmp("no operand", o_no_operand, 1'b1);
    lit(CLS_OTHER, 16'h0000);
    cmp("other", o_no_operand, 1'b0);
    $display("test literal done");
  endtask
  task automatic t_write;
    @(posedge i_core_clk);
    i_dst_mode <= MODE_INDIRECT;
    i_src_reg <= 4'h1;
    i_dst_write <= 1'b1;
    i_wr_data <= 16'hBEEF;
    fire(CLS_MOVE);
    i_dst_write <= 1'b0;
    cmp("write strobe", o_x_wr_en, 1'b1);
    cmp("write addr", o_x_wr_addr, 16'h0000);
    cmp("write data", o_x_wr_data, 16'hBEEF);
    $display("test write done");
  endtask
  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    t_mac();
    t_modulo();
    t_bad();
    t_literal();
    t_write();
    close_out();
  end
endmodule
